// *** core/compare_pkg.sv ***
// Shared definitions for the contact comparison unit.
// Assumes one scan clock domain and a sequencer that issues one instruction per request.
package compare_pkg;
   // Function numbers of the comparison instructions
   localparam logic [7:0] FN_LOAD_EQ = 8'hE0; // 224
   localparam logic [7:0] FN_LOAD_GT = 8'hE1; // 225
   localparam logic [7:0] FN_LOAD_LT = 8'hE2; // 226
   localparam logic [7:0] FN_LOAD_NE = 8'hE4; // 228
   localparam logic [7:0] FN_LOAD_LE = 8'hE5; // 229
   localparam logic [7:0] FN_LOAD_GE = 8'hE6; // 230
   localparam logic [7:0] FN_SER_BASE = 8'hE8; // 232
   localparam logic [7:0] FN_PAR_BASE = 8'hF0; // 240
   localparam logic [7:0] FN_GROUP_MASK = 8'hF8;
   localparam logic [7:0] FN_LOAD_BASE = 8'hE0;
   localparam logic [2:0] REL_MASK = 3'h7;
   // Relation codes (low three bits of the function number)
   localparam logic [2:0] REL_EQ = 3'h0;
   localparam logic [2:0] REL_GT = 3'h1;
   localparam logic [2:0] REL_LT = 3'h2;
   localparam logic [2:0] REL_NE = 3'h4;
   localparam logic [2:0] REL_LE = 3'h5;
   localparam logic [2:0] REL_GE = 3'h6;
   // Sign bit positions
   localparam int SIGN16 = 15;
   localparam int SIGN32 = 31;
   // Reset values
   localparam logic RUNG_RESET = 1'b0;
   // Blink divider for the error indicator, 0.25 s half period at 125 MHz
   localparam int CLK_MHZ = 125;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

   // Operand source kinds
   typedef enum logic [2:0] {
      SRC_CONST = 3'h0, // Decimal or hex constant
      SRC_GROUPED = 3'h1, // Digit-grouped bit word
      SRC_TIMER = 3'h2,
      SRC_COUNTER = 3'h3,
      SRC_DATA = 3'h4,
      SRC_INDEX = 3'h5,
      SRC_BIT = 3'h6 // Single bit element, never legal
   } src_kind_e;

   // One operand as delivered by the sequencer
   typedef struct packed {
      src_kind_e kind;
      logic wide_counter; // Counter at or above wide_counter_base
      logic [15:0] low_word; // Named register, or low constant half
      logic [15:0] high_word; // Next register up, or high constant half
   } operand_s;

   // One instruction request
   typedef struct packed {
      logic valid;
      logic [7:0] func;
      logic wide; // 32-bit form
      operand_s first_operand;
      operand_s second_operand;
   } request_s;
endpackage

// *** core/contact_compare_unit.sv ***
// Contact comparison unit: decodes and evaluates load, series and parallel compare contacts.
// Assumes the sequencer presents a request for one cycle with operands already fetched.
//
// Behaviour
// RULE1 - Decode six load relations, 224 to 230
// RULE2 - Decode six series relations ANDed with rung
// RULE3 - Decode six parallel relations ORed with rung
// RULE4 - Result true exactly when relation holds
// RULE5 - Operands are signed, sign bit 15 or 31
// RULE6 - Load comparison starts new rung from rail
// RULE7 - Series comparison ANDs into rung accumulator
// RULE8 - Parallel comparison ORs into rung accumulator
// RULE9 - Narrow form on wide counter: program error
// RULE10 - Only word sources accepted, no bit elements
// RULE11 - Wide register operand: next register upper half
`timescale 1ns/1ps
module contact_compare_unit
   import compare_pkg::*;
#(
   parameter int BLINK_CYCLES = BLINK_HALF_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire request_s req,
   output logic rung, // Rung accumulator
   output logic result, // Raw relation result of last instruction
   output logic done, // One-cycle pulse when a request was evaluated
   output logic program_error, // Sticky until reset, blocks run state
   output logic run_allowed, // Low once a program error was found
   output logic error_led // Blinks while program_error is set
);

   typedef enum logic [2:0] {
      GRP_LOAD = 3'b001,
      GRP_SER = 3'b010,
      GRP_PAR = 3'b100
   } group_e;

   logic [31:0] a_val; // First operand widened
   logic [31:0] b_val; // Second operand widened
   logic signed [31:0] a_s;
   logic signed [31:0] b_s;
   logic rel_ok; // Relation holds
   logic rel_legal; // Relation code is one of the six
   logic grp_legal; // Function number in one of the groups
   group_e grp;
   logic bad_operand; // Operand breaks the source rules
   logic next_rung;
   logic [31:0] blink_cnt;
   logic blink_tick;

   // Build a 32-bit signed value from an operand
   function automatic logic [31:0] widen(input operand_s op, input logic wide);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (wide) begin
         v = {op.high_word, op.low_word}; // RULE11
      end else begin
         v = {{16{op.low_word[SIGN16]}}, op.low_word}; // RULE5
      end
      return v;
   endfunction

   // Operand legality for the selected form
   function automatic logic op_bad(input operand_s op, input logic wide);
      logic b;
      b = 1'b0;
      if (op.kind == SRC_BIT || op.kind == 3'h7) begin
         b = 1'b1; // RULE10
      end
      if (!wide && op.kind == SRC_COUNTER && op.wide_counter) begin
         b = 1'b1; // RULE9
      end
      return b;
   endfunction

   // Decode group and relation from the function number
   always_comb begin
      grp = GRP_LOAD;
      grp_legal = 1'b1;
      if ((req.func & FN_GROUP_MASK) == FN_LOAD_BASE) begin
         grp = GRP_LOAD; // RULE1
      end else if ((req.func & FN_GROUP_MASK) == FN_SER_BASE) begin
         grp = GRP_SER; // RULE2
      end else if ((req.func & FN_GROUP_MASK) == FN_PAR_BASE) begin
         grp = GRP_PAR; // RULE3
      end else begin
         grp_legal = 1'b0;
      end
   end

   // Signed relation evaluation
   always_comb begin
      a_val = widen(req.first_operand, req.wide);
      b_val = widen(req.second_operand, req.wide);
      a_s = signed'(a_val); // RULE5
      b_s = signed'(b_val);
      rel_legal = 1'b1;
      unique case (req.func[2:0] & REL_MASK)
         REL_EQ: rel_ok = (a_s == b_s); // RULE4
         REL_GT: rel_ok = (a_s > b_s);
         REL_LT: rel_ok = (a_s < b_s);
         REL_NE: rel_ok = (a_s != b_s);
         REL_LE: rel_ok = (a_s <= b_s);
         REL_GE: rel_ok = (a_s >= b_s);
         default: begin
            rel_ok = 1'b0; // Codes 3 and 7 are not instructions
            rel_legal = 1'b0;
         end
      endcase
      bad_operand = op_bad(req.first_operand, req.wide) | op_bad(req.second_operand, req.wide);
   end

   // Combine result into the rung
   always_comb begin
      next_rung = rung;
      unique case (grp)
         GRP_LOAD: next_rung = rel_ok; // RULE6
         GRP_SER: next_rung = rung & rel_ok; // RULE7
         GRP_PAR: next_rung = rung | rel_ok; // RULE8
      endcase
   end

   // Rung accumulator and result; faulty instructions leave it untouched.
   // Gating on program_error keeps a stopped controller from evaluating
   // anything further, matching a CPU that refuses to run.
   // The answer is registered, so done, result and rung all move on the
   // same edge and the sequencer can sample them together.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rung <= RUNG_RESET;
         result <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (req.valid && grp_legal && rel_legal && !bad_operand && !program_error) begin
            rung <= next_rung;
            result <= rel_ok; // RULE4
            done <= 1'b1;
         end
      end
   end

   // Program error is sticky: the controller must not run until reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         program_error <= 1'b0;
         run_allowed <= 1'b1;
      end else if (req.valid && grp_legal && bad_operand) begin
         program_error <= 1'b1; // RULE9
         run_allowed <= 1'b0;
      end
   end

   // Blink divider, an enable pulse every half period.
   // It runs free from reset so the indicator needs no extra start logic;
   // the first flash after an error may therefore come early, never late.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         blink_cnt <= 32'h0000_0000;
         blink_tick <= 1'b0;
      end else begin
         blink_tick <= 1'b0;
         if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
            blink_cnt <= 32'h0000_0000;
            blink_tick <= 1'b1;
         end else begin
            blink_cnt <= blink_cnt + 32'h0000_0001;
         end
      end
   end

   // Red error indicator toggles only while an error stands
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         error_led <= 1'b0;
      end else if (!program_error) begin
         error_led <= 1'b0;
      end else if (blink_tick) begin
         error_led <= ~error_led; // RULE9
      end
   end

   // Every load gives the same answer as the raw result
   load_result_a: assert property (@(posedge clk) disable iff (!resetn)
      done && ($past(req.func) & FN_GROUP_MASK) == FN_LOAD_BASE |-> rung == result) // RULE6
      else $error("load compare did not set rung");
   series_and_a: assert property (@(posedge clk) disable iff (!resetn)
      done && ($past(req.func) & FN_GROUP_MASK) == FN_SER_BASE |-> rung == ($past(rung) & result)) // RULE7
      else $error("series compare did not AND");
   parallel_or_a: assert property (@(posedge clk) disable iff (!resetn)
      done && ($past(req.func) & FN_GROUP_MASK) == FN_PAR_BASE |-> rung == ($past(rung) | result)) // RULE8
      else $error("parallel compare did not OR");
   signed_less_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && !req.wide && req.func == FN_LOAD_LT && !bad_operand && req.first_operand.low_word[SIGN16]
      && !req.second_operand.low_word[SIGN16] && !program_error |=> result && done) // RULE5
      else $error("negative operand not below positive");
   equal_rel_a: assert property (@(posedge clk) disable iff (!resetn)
      done && $past(req.func[2:0]) == REL_EQ |-> result == ($past(a_val) == $past(b_val))) // RULE4
      else $error("equal relation wrong");
   wide_error_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && grp_legal && !req.wide && req.first_operand.kind == SRC_COUNTER
      && req.first_operand.wide_counter |=> program_error && !run_allowed && !done) // RULE9
      else $error("narrow compare on wide counter not flagged");
   bit_source_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && (req.first_operand.kind == SRC_BIT || req.second_operand.kind == SRC_BIT) |=> !done) // RULE10
      else $error("bit element operand accepted");
   wide_pair_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.wide && req.func == FN_LOAD_GT && !program_error && !bad_operand
      && req.first_operand.high_word == 16'h0001 && req.second_operand.high_word == 16'h0000
      |=> result) // RULE11
      else $error("upper half not from higher register");
   error_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      program_error |=> program_error && !done) // RULE9
      else $error("program error cleared without reset");
   led_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      !program_error |=> !error_led || program_error) // RULE9
      else $error("indicator lit without error");

   // Decode guards: the sequencer may put any byte on func, and only the
   // eighteen listed numbers may ever reach the rung. Everything else must
   // pass through without touching the rung, so a corrupt program word cannot
   // silently change the logic line.
   unknown_func_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && !grp_legal |=> !done) // RULE1
      else $error("unknown function number accepted");

   // Codes 3 and 7 inside a group are not an instruction, and an error only with a bad operand
   gap_code_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && grp_legal && !rel_legal && !bad_operand && !program_error
      |=> !done && !program_error) // RULE1
      else $error("gap relation code acted");

   // A legal request is answered in the very next cycle, never later
   accept_done_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && grp_legal && rel_legal && !bad_operand && !program_error |=> done) // RULE1
      else $error("legal compare not answered");

   // The answer pulse never appears on its own
   done_cause_a: assert property (@(posedge clk) disable iff (!resetn)
      done |-> $past(req.valid)) // RULE4
      else $error("answer without request");

   // Rung and result stand until the next accepted instruction
   rung_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      !done |-> $stable(rung)) // RULE6
      else $error("rung moved without instruction");
   result_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      !done |-> $stable(result)) // RULE4
      else $error("result moved without instruction");

   // Each ordering relation checked on the signed view of the operands.
   // The signed view matters: an unsigned compare would rank a negative
   // value above every positive one.
   greater_rel_a: assert property (@(posedge clk) disable iff (!resetn)
      done && $past(req.func[2:0]) == REL_GT |-> result == ($past(a_s) > $past(b_s))) // RULE4
      else $error("greater relation wrong");
   less_rel_a: assert property (@(posedge clk) disable iff (!resetn)
      done && $past(req.func[2:0]) == REL_LT |-> result == ($past(a_s) < $past(b_s))) // RULE4
      else $error("less relation wrong");
   unequal_rel_a: assert property (@(posedge clk) disable iff (!resetn)
      done && $past(req.func[2:0]) == REL_NE |-> result == ($past(a_s) != $past(b_s))) // RULE4
      else $error("unequal relation wrong");
   at_most_a: assert property (@(posedge clk) disable iff (!resetn)
      done && $past(req.func[2:0]) == REL_LE |-> result == ($past(a_s) <= $past(b_s))) // RULE4
      else $error("at most relation wrong");
   at_least_a: assert property (@(posedge clk) disable iff (!resetn)
      done && $past(req.func[2:0]) == REL_GE |-> result == ($past(a_s) >= $past(b_s))) // RULE4
      else $error("at least relation wrong");

   // Narrow form copies bit 15 into the whole upper half
   narrow_sign_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && !req.wide |-> a_val[31:16] == {16{req.first_operand.low_word[SIGN16]}}) // RULE5
      else $error("narrow operand not sign extended");

   // Wide form takes the upper half from the next register up
   wide_high_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.wide |-> a_val[31:16] == req.first_operand.high_word) // RULE11
      else $error("wide operand upper half wrong");

   // The run permission is always the inverse of the error flag
   run_block_a: assert property (@(posedge clk) disable iff (!resetn)
      run_allowed != program_error) // RULE9
      else $error("run permission disagrees with error");

   // A bit element as first operand is a program error, not a compare
   word_source_a: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && grp_legal && req.first_operand.kind == SRC_BIT |=> program_error && !done) // RULE10
      else $error("bit element not flagged");

   // While the error stands the indicator flips on every divider pulse
   led_blink_a: assert property (@(posedge clk) disable iff (!resetn)
      program_error && blink_tick |=> error_led != $past(error_led)) // RULE9
      else $error("indicator did not blink");
endmodule

// *** test/compare_sequencer.sv ***
// Model of the instruction sequencer that feeds the contact comparison unit.
// Assumes one scan clock; requests are driven off the falling edge.
`timescale 1ns/1ps
module compare_sequencer
   import compare_pkg::*;
(
   input wire logic clk,
   output request_s req // Request toward the unit
);
   // Idle bus at time zero
   initial begin
      req = '0;
   end

   // Present one instruction for exactly one rising edge, operands already fetched
   task automatic issue(input logic [7:0] f, input logic w, input logic [31:0] a, input logic [31:0] b,
                        input src_kind_e k, input logic wc);
      @(negedge clk);
      req.valid = 1'b1;
      req.func = f;
      req.wide = w;
      // Upper half taken from the next register up
      req.first_operand = '{k, wc, a[15:0], a[31:16]};
      // Second operand is always a word source
      req.second_operand = '{SRC_DATA, 1'b0, b[15:0], b[31:16]};
      @(negedge clk);
      req.valid = 1'b0;
      // Stale low words of both operands are scrambled so a late sample cannot look right
      req.first_operand.low_word = ~a[15:0];
      req.second_operand.low_word = ~b[15:0];
   endtask
endmodule

// *** test/contact_compare_unit_test.sv ***
// Self-checking testbench for the contact comparison unit.
// Assumes the unit answers one cycle after it takes a request, blink divider shortened to 4.
`timescale 1ns/1ps
module contact_compare_unit_test;
   import compare_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   request_s req;
   logic rung, result, done, program_error, run_allowed, error_led;
   logic e_rung = 1'b0; // Expected rung accumulator
   int n_errors = 0;
   int checks = 0;

   // 125 MHz scan clock
   always #4 clk = ~clk;

   compare_sequencer u_seq (.clk(clk), .req(req));
   contact_compare_unit #(.BLINK_CYCLES(4)) u_dut (.clk(clk), .resetn(resetn), .req(req), .rung(rung),
      .result(result), .done(done), .program_error(program_error), .run_allowed(run_allowed),
      .error_led(error_led));

   // One compare for every one-bit result
   task automatic chk(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic close_out;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Reset held for eight cycles, then rung, done, run_allowed and program_error at their idle values
   task automatic do_reset;
      resetn = 1'b0;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      e_rung = 1'b0;
      chk("rung", 1'b0, rung);
      chk("done", 1'b0, done);
      chk("run_allowed", 1'b1, run_allowed);
      chk("program_error", 1'b0, program_error);
   endtask

   // One legal instruction; expectation from signed relation and rung combination
   task automatic run(input logic [7:0] f, input logic w, input logic [31:0] a, input logic [31:0] b);
      logic signed [31:0] x, y;
      logic e;
      x = w ? a : {{16{a[15]}}, a[15:0]};
      y = w ? b : {{16{b[15]}}, b[15:0]};
      case (f[2:0])
         3'h0: e = (x == y);
         3'h1: e = (x > y);
         3'h2: e = (x < y);
         3'h4: e = (x != y);
         3'h5: e = (x <= y);
         default: e = (x >= y);
      endcase
      // Load starts afresh, series ANDs, parallel ORs
      if (f[7:3] == FN_LOAD_BASE[7:3]) e_rung = e;
      else if (f[7:3] == FN_SER_BASE[7:3]) e_rung = e_rung & e;
      else e_rung = e_rung | e;
      u_seq.issue(f, w, a, b, SRC_CONST, 1'b0);
      chk("done", 1'b1, done);
      chk("result", e, result);
      chk("rung", e_rung, rung);
   endtask

   // Every relation of every group, negative and equal operands, junk in the ignored upper half
   task automatic sc_relations;
      logic [7:0] base [3];
      base = '{FN_LOAD_BASE, FN_SER_BASE, FN_PAR_BASE};
      for (int g = 0; g < 3; g++) begin
         for (int r = 0; r < 7; r++) begin
            if (r != 3) begin
               run(base[g] | 8'(r), 1'b0, 32'h5A5AFFFD, 32'h00000002);
               run(base[g] | 8'(r), 1'b0, 32'h00000002, 32'h00000002);
            end
         end
      end
   endtask

   // Wide form: sign at bit 31, upper half decides
   task automatic sc_wide;
      run(FN_LOAD_LT, 1'b1, 32'h80000000, 32'h00000001);
      run(FN_SER_BASE, 1'b1, 32'h00010000, 32'h00020000);
      run(FN_LOAD_GT, 1'b1, 32'h00010000, 32'h0000FFFF);
      run(FN_PAR_BASE | 8'h01, 1'b1, 32'h7FFFFFFF, 32'hFFFFFFFF);
   endtask

   // Unused function numbers pass without effect
   task automatic sc_ignored;
      u_seq.issue(FN_LOAD_BASE | 8'h03, 1'b0, 32'h1, 32'h1, SRC_CONST, 1'b0);
      chk("done", 1'b0, done);
      u_seq.issue(8'h10, 1'b0, 32'h1, 32'h1, SRC_CONST, 1'b0);
      chk("rung", e_rung, rung);
   endtask

   // Wide counter in narrow form, then a bit element: error, blink, later requests ignored
   task automatic sc_error;
      logic l;
      for (int i = 0; i < 2; i++) begin
         do_reset();
         if (i == 0) u_seq.issue(FN_LOAD_EQ, 1'b0, 32'h5, 32'h5, SRC_COUNTER, 1'b1);
         else u_seq.issue(FN_LOAD_EQ, 1'b0, 32'h5, 32'h5, SRC_BIT, 1'b0);
         chk("done", 1'b0, done);
         chk("program_error", 1'b1, program_error);
         chk("run_allowed", 1'b0, run_allowed);
         u_seq.issue(FN_LOAD_EQ, 1'b0, 32'h5, 32'h5, SRC_CONST, 1'b0);
         chk("rung", 1'b0, rung);
         l = error_led;
         repeat (4) @(negedge clk);
         chk("error_led", ~l, error_led);
      end
   endtask

   // Main sequence
   initial begin
      do_reset();
      sc_relations();
      sc_wide();
      sc_ignored();
      sc_error();
      close_out();
   end

   // Hang guard: a run past its bound counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      close_out();
   end
endmodule
